// File: rtl/rfa_top.sv
// Operation
// R1 - Each write of the cutoff target starts a filter calibration that ends within 100 us.
// R2 - The cutoff target is an 8-bit value in its own register, written by the host.
// R3 - The receive filter is on after reset and is bypassed while control bit 0 is clear.
// R4 - Rewriting the target with the same value reruns the calibration.
// R5 - Control bit 4 set puts the ADC into its reduced-current mode.
// R6 - Clock configuration bit 5 set routes the ADC clock through the duty-cycle restorer.
// R7 - Clock configuration bit 4 picks the ADC clock source, reference or synthesizer.
// R8 - The host enables the restorer only for an asymmetric reference clock.
// R9 - A 3-bit field of the bias register selects the ADC bias setting.
// R10 - Samples are 10 bits wide and move one pipeline stage per clock edge.
// R11 - The ADC can be fully powered down in half-duplex operation.
// R12 - Receive latency is 10 cycles in half-duplex and 10.5 in full-duplex mode; the code taps stage 11 (LAT_FULL) in full-duplex.
// R13 - A low interface mode input selects half-duplex operation.
// R14 - After reset the ADC clock comes from the buffered reference input.
// R15 - Calibration is busy from the target write to its end; a new write restarts it.
// R16 - Undescribed register bits read back as written and steer nothing.

module rfa_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 16
) (
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem_ff;
    logic [AW-1:0]               wp_ff;
    logic [AW-1:0]               rp_ff;
    logic [AW:0]                 cnt_ff;
  } rfa_fifo_state_t;

  rfa_fifo_state_t st_ff;
  rfa_fifo_state_t nxt_st;
  logic            push;
  logic            pop;

  assign in_ready  = (st_ff.cnt_ff != (AW+1)'(DEPTH));
  assign out_valid = (st_ff.cnt_ff != '0);
  assign out_data  = st_ff.mem_ff[st_ff.rp_ff];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    nxt_st = st_ff;
    if (push) begin
      nxt_st.mem_ff[st_ff.wp_ff] = in_data;
      nxt_st.wp_ff = st_ff.wp_ff + AW'(1);
    end
    if (pop) begin
      nxt_st.rp_ff = st_ff.rp_ff + AW'(1);
    end
    nxt_st.cnt_ff = st_ff.cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
endmodule : rfa_fifo

module rfa_top
  import rfa_pkg::*;
#(
  parameter int CAL_LEN = CAL_CYCLES
) (
  input  wire logic                mclk,
  input  wire logic                rst,
  input  wire rfa_reg_req_t        reg_req,
  output logic [7:0]               reg_rdata,
  input  wire logic                duplex_mode_pin,
  input  wire logic                adc_pd_req_pin,
  input  wire logic                adc_sample_valid,
  input  wire logic [SAMPLE_W-1:0] adc_sample,
  output logic                     adc_ready,
  output logic                     adc_data_bus_valid,
  input  wire logic                adc_data_bus_ready,
  output logic [SAMPLE_W-1:0]      adc_data_bus,
  output rfa_ctrl_out_t            ctrl_out
);

  rfa_state_t          st_ff;
  rfa_state_t          nxt_st;
  logic                half_duplex;
  logic                tgt_wr;
  logic                tap_valid;
  logic [SAMPLE_W-1:0] tap_data;
  logic                fifo_in_ready;

  assign half_duplex = !st_ff.mode_sync_ff[1]; // [R13]
  assign tgt_wr      = reg_req.wr_en && (reg_req.addr == TARGET_OFS);
  assign tap_valid   = half_duplex ? st_ff.vpipe_ff[LAT_HALF-1]
                                   : st_ff.vpipe_ff[LAT_FULL-1]; // [R12]
  assign tap_data    = half_duplex ? st_ff.pipe_ff[LAT_HALF-1]
                                   : st_ff.pipe_ff[LAT_FULL-1]; // [R12]
  // The ADC cannot pause; a full FIFO shows as adc_ready low and drops
  assign adc_ready   = fifo_in_ready;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.mode_sync_ff = {st_ff.mode_sync_ff[0], duplex_mode_pin};
    nxt_st.pd_sync_ff   = {st_ff.pd_sync_ff[0], adc_pd_req_pin};
    if (reg_req.wr_en) begin
      case (reg_req.addr)
        CLK_CFG_OFS: nxt_st.clk_cfg_ff = reg_req.wdata; // [R6] [R7] [R16]
        CTRL_OFS:    nxt_st.ctrl_ff    = reg_req.wdata; // [R3] [R5] [R16]
        TARGET_OFS:  nxt_st.target_ff  = reg_req.wdata; // [R2]
        BIAS_OFS:    nxt_st.bias_ff    = reg_req.wdata; // [R9] [R16]
        default: ;
      endcase
    end
    if (reg_req.rd_en) begin
      case (reg_req.addr)
        CLK_CFG_OFS: nxt_st.rdata_ff = st_ff.clk_cfg_ff;
        CTRL_OFS:    nxt_st.rdata_ff = st_ff.ctrl_ff;
        TARGET_OFS:  nxt_st.rdata_ff = st_ff.target_ff;
        BIAS_OFS:    nxt_st.rdata_ff = st_ff.bias_ff;
        STATUS_OFS: begin
          nxt_st.rdata_ff = 8'h00;
          nxt_st.rdata_ff[STAT_BUSY_BIT] = st_ff.cal_busy_ff;
          nxt_st.rdata_ff[STAT_HALF_BIT] = half_duplex;
          nxt_st.rdata_ff[STAT_PD_BIT]   = ctrl_out.adc_power_down;
        end
        default: nxt_st.rdata_ff = 8'h00;
      endcase
    end
    // Any target write, same value or not, restarts the count
    if (tgt_wr) begin
      nxt_st.cal_busy_ff = 1'b1; // [R1] [R4] [R15]
      nxt_st.cal_cnt_ff  = '0;
    end else if (st_ff.cal_busy_ff) begin
      if (st_ff.cal_cnt_ff == CAL_CNT_W'(CAL_LEN - 2)) begin
        nxt_st.cal_busy_ff = 1'b0; // [R1]
      end else begin
        nxt_st.cal_cnt_ff = st_ff.cal_cnt_ff + CAL_CNT_W'(1);
      end
    end
    nxt_st.pipe_ff[0]  = adc_sample; // [R10]
    nxt_st.vpipe_ff[0] = adc_sample_valid && !ctrl_out.adc_power_down;
    for (int i = 1; i < LAT_FULL; i++) begin
      nxt_st.pipe_ff[i]  = st_ff.pipe_ff[i-1]; // [R10]
      nxt_st.vpipe_ff[i] = st_ff.vpipe_ff[i-1];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_ff            <= '0;
      st_ff.clk_cfg_ff <= CLK_CFG_RST; // [R14]
      st_ff.ctrl_ff    <= CTRL_RST;    // [R3]
      st_ff.target_ff  <= TARGET_RST;
      st_ff.bias_ff    <= BIAS_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign reg_rdata = st_ff.rdata_ff;
  always_comb begin
    ctrl_out.filter_enable      = st_ff.ctrl_ff[CTRL_FILT_EN_BIT]; // [R3]
    ctrl_out.cutoff_target      = st_ff.target_ff;                 // [R2]
    ctrl_out.adc_low_power      = st_ff.ctrl_ff[CTRL_LOW_PWR_BIT]; // [R5]
    ctrl_out.duty_restore_en    = st_ff.clk_cfg_ff[CLK_DCR_BIT];   // [R6]
    ctrl_out.adc_clk_from_synth = st_ff.clk_cfg_ff[CLK_FROM_SYN_BIT]; // [R7]
    ctrl_out.adc_bias_sel       = st_ff.bias_ff[BIAS_LSB +: BIAS_W]; // [R9]
    // Full power-down only honoured in half-duplex
    ctrl_out.adc_power_down     = half_duplex && st_ff.pd_sync_ff[1]; // [R11]
    ctrl_out.cal_busy           = st_ff.cal_busy_ff;               // [R15]
  end

  rfa_fifo #(
    .WIDTH (SAMPLE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .mclk      (mclk),
    .rst       (rst),
    .in_valid  (tap_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (tap_data),
    .out_valid (adc_data_bus_valid),
    .out_ready (adc_data_bus_ready),
    .out_data  (adc_data_bus)
  );

  sequence s_tgt_write;
    reg_req.wr_en && reg_req.addr == TARGET_OFS;
  endsequence

  sequence s_cal_running;
    ctrl_out.cal_busy && st_ff.cal_cnt_ff == '0;
  endsequence

  sequence s_half_sample;
    adc_sample_valid && !ctrl_out.adc_power_down && half_duplex;
  endsequence

  a_cal_start: assert property (@(posedge mclk) disable iff (rst) // [R1]
    s_tgt_write |=> s_cal_running)
    else $error("target write did not start calibration");

  a_cal_restart: assert property (@(posedge mclk) disable iff (rst) // [R15]
    ctrl_out.cal_busy && st_ff.cal_cnt_ff > 3 ##0 s_tgt_write
    |=> s_cal_running ##1 ctrl_out.cal_busy)
    else $error("target write in calibration did not restart it");

  a_cal_end: assert property (@(posedge mclk) disable iff (rst) // [R1]
    ctrl_out.cal_busy && st_ff.cal_cnt_ff == CAL_CNT_W'(CAL_LEN - 2)
    && !tgt_wr |=> !ctrl_out.cal_busy)
    else $error("calibration overran its length");

  a_target_hold: assert property (@(posedge mclk) disable iff (rst) // [R2]
    s_tgt_write |=> ctrl_out.cutoff_target == $past(reg_req.wdata))
    else $error("cutoff target not stored");

  a_filter_bypass: assert property (@(posedge mclk) disable iff (rst) // [R3]
    reg_req.wr_en && reg_req.addr == CTRL_OFS
    |=> ctrl_out.filter_enable == $past(reg_req.wdata[CTRL_FILT_EN_BIT])
        && ctrl_out.adc_low_power == $past(reg_req.wdata[CTRL_LOW_PWR_BIT]))
    else $error("filter or low power bit wrong");

  a_clk_select: assert property (@(posedge mclk) disable iff (rst) // [R7]
    reg_req.wr_en && reg_req.addr == CLK_CFG_OFS
    |=> ctrl_out.adc_clk_from_synth == $past(reg_req.wdata[CLK_FROM_SYN_BIT])
        && ctrl_out.duty_restore_en == $past(reg_req.wdata[CLK_DCR_BIT]))
    else $error("clock source or restorer bit wrong");

  a_bias_field: assert property (@(posedge mclk) disable iff (rst) // [R9]
    reg_req.wr_en && reg_req.addr == BIAS_OFS
    |=> ctrl_out.adc_bias_sel == $past(reg_req.wdata[BIAS_W-1:0]))
    else $error("bias field wrong");

  a_reset_defaults: assert property (@(posedge mclk) // [R14]
    rst |=> !ctrl_out.adc_clk_from_synth && ctrl_out.filter_enable)
    else $error("wrong clock source or filter state after reset");

  a_pd_half_only: assert property (@(posedge mclk) disable iff (rst) // [R11]
    ctrl_out.adc_power_down |-> half_duplex)
    else $error("ADC powered down outside half-duplex");

  a_half_latency: assert property (@(posedge mclk) disable iff (rst) // [R12]
    s_half_sample ##1 half_duplex [*8] ##1 half_duplex ##1 half_duplex
    |-> tap_valid && tap_data == $past(adc_sample, 10))
    else $error("half-duplex latency not 10 cycles");

endmodule : rfa_top

// File: rtl/rfa_pkg.sv
package rfa_pkg;

  localparam logic [7:0] CLK_CFG_OFS   = 8'h04;
  localparam logic [7:0] CTRL_OFS      = 8'h07;
  localparam logic [7:0] TARGET_OFS    = 8'h08;
  localparam logic [7:0] BIAS_OFS      = 8'h13;
  localparam logic [7:0] STATUS_OFS    = 8'h1f;

  localparam logic [7:0] CLK_CFG_RST   = 8'h00;
  localparam logic [7:0] CTRL_RST      = 8'h01;
  localparam logic [7:0] TARGET_RST    = 8'h00;
  localparam logic [7:0] BIAS_RST      = 8'h00;

  localparam int CTRL_FILT_EN_BIT = 0;
  localparam int CTRL_LOW_PWR_BIT = 4;
  localparam int CLK_FROM_SYN_BIT = 4;
  localparam int CLK_DCR_BIT      = 5;
  localparam int BIAS_LSB         = 0;
  localparam int BIAS_W           = 3;
  localparam int STAT_BUSY_BIT    = 0;
  localparam int STAT_HALF_BIT    = 1;
  localparam int STAT_PD_BIT      = 2;

  localparam int SAMPLE_W         = 10;
  localparam int LAT_HALF         = 10;
  localparam int LAT_FULL         = 11;
  localparam int FIFO_DEPTH       = 16;

  localparam int CLK_PERIOD_PS    = 4000;
  localparam int CAL_TIME_US      = 100;
  localparam int CAL_CYCLES       = CAL_TIME_US * 1000000 / CLK_PERIOD_PS;
  localparam int CAL_CNT_W        = 16;

  typedef struct packed {
    logic       wr_en;
    logic       rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rfa_reg_req_t;

  typedef struct packed {
    logic                 filter_enable;
    logic [7:0]           cutoff_target;
    logic                 adc_low_power;
    logic                 duty_restore_en;
    logic                 adc_clk_from_synth;
    logic [BIAS_W-1:0]    adc_bias_sel;
    logic                 adc_power_down;
    logic                 cal_busy;
  } rfa_ctrl_out_t;

  typedef struct packed {
    logic [7:0]                         clk_cfg_ff;
    logic [7:0]                         ctrl_ff;
    logic [7:0]                         target_ff;
    logic [7:0]                         bias_ff;
    logic                               cal_busy_ff;
    logic [CAL_CNT_W-1:0]               cal_cnt_ff;
    logic [7:0]                         rdata_ff;
    logic [1:0]                         mode_sync_ff;
    logic [1:0]                         pd_sync_ff;
    logic [LAT_FULL-1:0][SAMPLE_W-1:0]  pipe_ff;
    logic [LAT_FULL-1:0]                vpipe_ff;
  } rfa_state_t;

endpackage : rfa_pkg

// File: dv/rfa_backend_model.sv
module rfa_backend_model
  import rfa_pkg::*;
(
  input  wire logic                mclk,
  input  wire logic                rst,
  input  wire logic                stall,
  input  wire logic                valid,
  input  wire logic [SAMPLE_W-1:0] data,
  output logic                     ready
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [SAMPLE_W-1:0] got_q[$];

  // Stall holds ready low so the bench can fill the buffer to the brim
  assign ready = !stall && !rst;

  always @(posedge mclk) begin
    if (valid && ready) begin
      got_q.push_back(data);
    end
  end
endmodule : rfa_backend_model

// File: dv/rfa_top_tb_top.sv
module rfa_top_tb_top
  import rfa_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int CAL = 16;
  logic                mclk, rst, duplex_mode_pin, adc_pd_req_pin;
  logic                adc_sample_valid, adc_ready, stall;
  logic                adc_data_bus_valid, adc_data_bus_ready;
  logic [SAMPLE_W-1:0] adc_sample, adc_data_bus;
  logic [7:0]          reg_rdata, d;
  rfa_reg_req_t        reg_req;
  rfa_ctrl_out_t       ctrl_out;
  int                  failures, samples_checked, n;

  rfa_top #(.CAL_LEN(CAL)) i_dut (.mclk(mclk), .rst(rst),
    .reg_req(reg_req), .reg_rdata(reg_rdata),
    .duplex_mode_pin(duplex_mode_pin), .adc_pd_req_pin(adc_pd_req_pin),
    .adc_sample_valid(adc_sample_valid), .adc_sample(adc_sample),
    .adc_ready(adc_ready), .adc_data_bus_valid(adc_data_bus_valid),
    .adc_data_bus_ready(adc_data_bus_ready),
    .adc_data_bus(adc_data_bus), .ctrl_out(ctrl_out));
  rfa_backend_model i_be (.mclk(mclk), .rst(rst), .stall(stall),
    .valid(adc_data_bus_valid), .data(adc_data_bus),
    .ready(adc_data_bus_ready));

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  task automatic cyc(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask : cyc

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    reg_req.wr_en = 1'b1;
    reg_req.addr  = a;
    reg_req.wdata = v;
    cyc(1);
    reg_req.wr_en = 1'b0;
    cyc(1);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    reg_req.rd_en = 1'b1;
    reg_req.addr  = a;
    cyc(1);
    reg_req.rd_en = 1'b0;
    cyc(1);
    v = reg_rdata;
  endtask : rd

  task automatic reset_values();
    rd(CLK_CFG_OFS, d); check(d, CLK_CFG_RST);
    rd(CTRL_OFS, d); check(d, CTRL_RST);
    rd(TARGET_OFS, d); check(d, TARGET_RST);
    rd(BIAS_OFS, d); check(d, BIAS_RST);
    rd(8'h20, d); check(d, 8'h00);
    check(ctrl_out.filter_enable, 1'b1);
    check(ctrl_out.adc_clk_from_synth, 1'b0);
  endtask : reset_values

  task automatic reg_fields();
    wr(CTRL_OFS, 8'h10);
    check({ctrl_out.filter_enable, ctrl_out.adc_low_power}, 2'b01);
    rd(CTRL_OFS, d); check(d, 8'h10);
    wr(CLK_CFG_OFS, 8'h20);
    check({ctrl_out.duty_restore_en, ctrl_out.adc_clk_from_synth}, 2'b10);
    wr(CLK_CFG_OFS, 8'h10);
    check({ctrl_out.duty_restore_en, ctrl_out.adc_clk_from_synth}, 2'b01);
    wr(BIAS_OFS, 8'hfd);
    check(ctrl_out.adc_bias_sel, 3'h5);
    rd(BIAS_OFS, d); check(d, 8'hfd);
  endtask : reg_fields

  // Busy is counted from the cycle after the write is taken
  task automatic cal_run(input logic [7:0] v, input bit again);
    wr(TARGET_OFS, v);
    check(ctrl_out.cutoff_target, v);
    if (again) begin
      cyc(4);
      wr(TARGET_OFS, v);
    end
    n = 1;
    while (ctrl_out.cal_busy === 1'b1 && n < 2 * CAL) begin
      n++;
      cyc(1);
    end
    check(n, CAL - 1);
  endtask : cal_run

  task automatic latency(input logic [9:0] s, input int exp);
    adc_sample_valid = 1'b1;
    adc_sample = s;
    cyc(1);
    adc_sample_valid = 1'b0;
    n = 1;
    while (adc_data_bus_valid !== 1'b1 && n < 40) begin
      cyc(1);
      n++;
    end
    check(n, exp);
    check(adc_data_bus, s);
  endtask : latency

  task automatic power_down();
    adc_pd_req_pin = 1'b1;
    cyc(4);
    check(ctrl_out.adc_power_down, 1'b1);
    rd(STATUS_OFS, d); check(d, 8'h06);
    adc_sample_valid = 1'b1;
    cyc(1);
    adc_sample_valid = 1'b0;
    cyc(16);
    check(adc_data_bus_valid, 1'b0);
    duplex_mode_pin = 1'b1;
    cyc(4);
    check(ctrl_out.adc_power_down, 1'b0);
    adc_pd_req_pin = 1'b0;
  endtask : power_down

  // Stalled back end: words past the buffer depth are dropped at the tap
  task automatic fill_drain();
    stall = 1'b1;
    n = i_be.got_q.size();
    adc_sample_valid = 1'b1;
    for (int i = 0; i < 20; i++) begin
      adc_sample = 10'(i + 8'h40);
      cyc(1);
    end
    adc_sample_valid = 1'b0;
    cyc(15);
    check(adc_ready, 1'b0);
    stall = 1'b0;
    cyc(20);
    check(i_be.got_q.size() - n, FIFO_DEPTH);
    check(i_be.got_q[n + 15], 10'h04f);
    check(adc_data_bus_valid, 1'b0);
  endtask : fill_drain

  task automatic print_verdict();
    $display("failures %0d samples_checked %0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : print_verdict

  initial begin
    #80000;
    failures++;
    print_verdict();
  end

  initial begin
    rst = 1'b1;
    reg_req = '0;
    duplex_mode_pin = 1'b0;
    adc_pd_req_pin = 1'b0;
    adc_sample_valid = 1'b0;
    adc_sample = '0;
    stall = 1'b0;
    failures = 0;
    samples_checked = 0;
    cyc(8);
    rst = 1'b0;
    reset_values();
    reg_fields();
    cal_run(8'h5a, 1'b0);
    cal_run(8'h5a, 1'b1);
    latency(10'h2a5, LAT_HALF + 1);
    duplex_mode_pin = 1'b1;
    cyc(4);
    latency(10'h15a, LAT_FULL + 1);
    duplex_mode_pin = 1'b0;
    cyc(4);
    power_down();
    fill_drain();
    print_verdict();
  end
endmodule : rfa_top_tb_top
